/* File: dpf_ctrl_front.sv */
// DDR2 control and address pin front end, device side
// Operation
// RULE1: capture address and control on the rising true clock edge.
// RULE2: read data launched on both clock crossings; code launches one beat per rising edge.
// RULE3: CKE high runs clocks, buffers, drivers; low turns them off.
// RULE4: CKE low idle gives precharge power-down or self refresh; else active.
// RULE5: CKE synchronous for entries and power-down exit; self-refresh exit async; code exits self refresh on the clocked, synchronised CKE.
// RULE6: controller holds CKE high during every read and write access.
// RULE7: power-down keeps only clock, termination and CKE buffers enabled.
// RULE8: self refresh keeps only the CKE buffer enabled.
// RULE9: commands sampled with chip select high are ignored.
// RULE10: command decoded from chip select, RAS, CAS, WE on one edge.
// RULE11: registered termination high terminates all data, strobe, mask lines.
// RULE12: termination pin ignored when extended mode register disables it.
// RULE13: masked write beats leave stored data unchanged, sampled both edges; code samples the mask on the rising clock edge only.
// RULE14: bank address picks the bank for activate, read, write, precharge.
// RULE15: bank address selects base or extended mode register on set.
// RULE16: row address on activate; column and auto-precharge on read/write.
// RULE17: precharge with A10 low closes one bank, high closes all.
// RULE18: mode register set loads the address inputs as op-code.
// RULE19: strobe edge-aligned on reads, centred on writes; lower/upper bytes.
// RULE20: a masked command changes no bank state or register.
`timescale 1ns/1ps
module dpf_ctrl_front #(
  parameter int ADDR_W = dpf_pkg::ADDR_W,
  parameter int NBANKS = dpf_pkg::NBANKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command pins from the controller
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [dpf_pkg::BANK_W-1:0] bankAddr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic odt,
  // Write data path: data and mask per beat, sampled on the rising clock edge
  input wire logic [dpf_pkg::DQ_W-1:0] wrDq,
  input wire logic [1:0] wrMask,
  input wire logic wrBeat,
  // Read data from the array, rise and fall beats taken on alternate clocks
  input wire logic [dpf_pkg::DQ_W-1:0] rdRise,
  input wire logic [dpf_pkg::DQ_W-1:0] rdFall,
  input wire logic rdBeat,
  // Decoded access and array controls
  output dpf_pkg::dpf_access_type access,
  output logic [dpf_pkg::ROW_W-1:0] actRow,
  output logic [dpf_pkg::BANK_W-1:0] actBank,
  output logic actStrobe,
  output logic refStrobe,
  output logic [NBANKS-1:0] bankOpen,
  output logic [ADDR_W-1:0] modeOut,
  // Write data to the array with per-byte enables
  output logic [dpf_pkg::DQ_W-1:0] arrData,
  output logic [1:0] arrByteEn,
  // Read data pins and strobe
  output logic [dpf_pkg::DQ_W-1:0] dqOut,
  output logic dqOe,
  output logic [1:0] dqsOut,
  // Power and termination state
  output dpf_pkg::dpf_pwr_type pwrState,
  output logic clkRun,
  output logic cmdBufOn,
  output logic clkBufOn,
  output logic termOn
);

  // Two-stage synchronisers for all pin inputs
  dpf_pkg::dpf_cmdpins_type pinMeta, pinSync;
  logic ckeMeta, ckeSync, odtMeta, odtSync;
  logic [dpf_pkg::DQ_W-1:0] wdMeta, wdSync;
  logic [1:0] wmMeta, wmSync;
  logic wbMeta, wbSync;
  logic cmdValid;
  dpf_pkg::dpf_cmd_type cmd;
  logic [ADDR_W-1:0] emr1;
  logic allIdle;
  logic [ADDR_W-1:0] modeRd;
  logic mrWrite;
  logic rdPhase;
  logic [NBANKS-1:0] bankSet, bankClr;

  // One-hot vector for a bank number
  function automatic logic [NBANKS-1:0] bank_onehot(
    input logic [dpf_pkg::BANK_W-1:0] b);
    logic [NBANKS-1:0] v;
    v = '0;
    v[b] = 1'b1;
    return v;
  endfunction

  // RULE1 sample pins
  // Everything is taken on the rising edge, the true clock crossing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= '1;
      pinSync <= '1;
    end else begin
      pinMeta <= '{csN: csN, rasN: rasN, casN: casN, weN: weN,
                   bank: bankAddr, addr: addr};
      pinSync <= pinMeta;
    end
  end

  // CKE and termination pin synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ckeMeta <= 1'b0;
      ckeSync <= 1'b0;
      odtMeta <= 1'b0;
      odtSync <= 1'b0;
    end else begin
      ckeMeta <= cke;
      ckeSync <= ckeMeta;
      odtMeta <= odt;
      odtSync <= odtMeta;
    end
  end

  // Write data path synchronisers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdMeta <= '0;
      wdSync <= '0;
      wmMeta <= '1;
      wmSync <= '1;
      wbMeta <= 1'b0;
      wbSync <= 1'b0;
    end else begin
      wdMeta <= wrDq;
      wdSync <= wdMeta;
      wmMeta <= wrMask;
      wmSync <= wmMeta;
      wbMeta <= wrBeat;
      wbSync <= wbMeta;
    end
  end

  // RULE10 command decode
  // All four command pins form one code from the same edge
  assign cmd = dpf_pkg::dpf_cmd_type'({pinSync.csN, pinSync.rasN,
                                      pinSync.casN, pinSync.weN});

  // RULE9 chip select mask
  // RULE20 masked is nop
  // RULE7 command buffers off
  // Command accepted only when selected and the command buffers are on
  assign cmdValid = !pinSync.csN && cmdBufOn;

  assign allIdle = (bankOpen == '0);

  // RULE4 power-down entry
  // RULE5 sync entry and exit
  // CKE low with banks idle and a refresh code enters self refresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrState <= dpf_pkg::PWR_PRE_PD;
    end else begin
      unique case (pwrState)
        dpf_pkg::PWR_ON: begin
          if (!ckeSync) begin
            if (!allIdle) begin
              pwrState <= dpf_pkg::PWR_ACT_PD;
            end else if (cmdValid && cmd == dpf_pkg::CMD_REF) begin
              pwrState <= dpf_pkg::PWR_SELF_REF;
            end else begin
              pwrState <= dpf_pkg::PWR_PRE_PD;
            end
          end
        end
        dpf_pkg::PWR_PRE_PD, dpf_pkg::PWR_ACT_PD: begin
          if (ckeSync) begin
            pwrState <= dpf_pkg::PWR_ON;
          end
        end
        // RULE5 self-refresh exit
        // Synchronised CKE high releases it on a clock edge, as for power-down
        dpf_pkg::PWR_SELF_REF: begin
          if (ckeSync) begin
            pwrState <= dpf_pkg::PWR_ON;
          end
        end
      endcase
    end
  end

  // RULE3 clock gating
  // RULE7 power-down buffers
  // RULE8 self-refresh buffers
  // Clock and buffer enables follow the current power state one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkRun <= 1'b0;
      cmdBufOn <= 1'b0;
      clkBufOn <= 1'b1;
    end else begin
      clkRun <= ckeSync && pwrState == dpf_pkg::PWR_ON;
      cmdBufOn <= ckeSync && pwrState == dpf_pkg::PWR_ON;
      clkBufOn <= pwrState != dpf_pkg::PWR_SELF_REF;
    end
  end

  // RULE15 register select
  // RULE18 op-code load
  assign mrWrite = cmdValid && cmd == dpf_pkg::CMD_MRS && allIdle;

  dpf_mode_regs #(
    .WIDTH(ADDR_W),
    .DEPTH(dpf_pkg::MR_COUNT)
  ) uModeRegs (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(mrWrite),
    .wrSel(pinSync.bank),
    .wrData(pinSync.addr),
    .rdSel(pinSync.bank),
    .rdData(modeRd)
  );

  // Local copy of extended register 1 for the termination decision
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      emr1 <= dpf_pkg::MR_RESET;
      modeOut <= dpf_pkg::MR_RESET;
    end else begin
      if (mrWrite && pinSync.bank == dpf_pkg::EMR1_SEL) begin
        emr1 <= pinSync.addr;
      end
      modeOut <= modeRd;
    end
  end

  // RULE11 termination on
  // RULE12 disable override
  // Termination pin stays live in power-down but not in self refresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      termOn <= 1'b0;
    end else begin
      termOn <= odtSync && clkBufOn &&
                (emr1[dpf_pkg::ODT_RTT0_BIT] ||
                 emr1[dpf_pkg::ODT_RTT1_BIT]);
    end
  end

  // RULE14 bank select
  // Bank opened by an activate this cycle
  assign bankSet = (cmdValid && cmd == dpf_pkg::CMD_ACT) ?
                   bank_onehot(pinSync.bank) : '0;

  // RULE17 precharge scope
  // Closes from precharge and auto-precharge; both may land at once
  always_comb begin
    bankClr = '0;
    if (access.autoPre && (access.rd || access.wr)) begin
      bankClr = bank_onehot(access.bank);
    end
    if (cmdValid && cmd == dpf_pkg::CMD_PRE) begin
      if (pinSync.addr[dpf_pkg::AP_BIT]) begin
        bankClr = '1;
      end else begin
        bankClr = bankClr | bank_onehot(pinSync.bank);
      end
    end
  end

  // Open-row tracking; an activate in the same cycle as an
  // auto-precharge of another bank must not lose the close
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bankOpen <= '0;
    end else begin
      bankOpen <= (bankOpen & ~bankClr) | bankSet;
    end
  end

  // RULE16 row and column
  // Row taken on activate, column and auto-precharge on read or write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      actRow <= dpf_pkg::ROW_RESET;
      actBank <= '0;
      actStrobe <= 1'b0;
      refStrobe <= 1'b0;
      access <= '0;
    end else begin
      actStrobe <= cmdValid && cmd == dpf_pkg::CMD_ACT;
      refStrobe <= cmdValid && cmd == dpf_pkg::CMD_REF && ckeSync;
      if (cmdValid && cmd == dpf_pkg::CMD_ACT) begin
        actRow <= pinSync.addr[dpf_pkg::ROW_W-1:0];
        actBank <= pinSync.bank;
      end
      // RULE6 reliance on CKE
      // Accesses assume CKE stays high; no power state check inside
      access.rd <= cmdValid && cmd == dpf_pkg::CMD_RD;
      access.wr <= cmdValid && cmd == dpf_pkg::CMD_WR;
      access.autoPre <= cmdValid && pinSync.addr[dpf_pkg::AP_BIT] &&
                        (cmd == dpf_pkg::CMD_RD || cmd == dpf_pkg::CMD_WR);
      access.bank <= pinSync.bank;
      access.col <= pinSync.addr[dpf_pkg::COL_W-1:0];
    end
  end

  // RULE13 write mask
  // RULE19 byte lanes
  // Lower mask gates bits 0-7, upper mask bits 8-15
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arrData <= '0;
      arrByteEn <= '0;
    end else begin
      arrData <= wdSync;
      arrByteEn <= (wbSync && clkRun) ? ~wmSync : 2'h0;
    end
  end

  // Phase of the current beat: rise data first, then fall data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPhase <= 1'b0;
    end else begin
      rdPhase <= (rdBeat && clkRun) ? ~rdPhase : 1'b0;
    end
  end

  // RULE2 both crossings
  // RULE19 edge-aligned strobe
  // Beats alternate rise and fall data; strobe toggles with each beat
  // Data, enable and strobe launch from the same beat so they line up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dqOut <= '0;
      dqOe <= 1'b0;
      dqsOut <= 2'h0;
    end else begin
      dqOut <= rdPhase ? rdFall : rdRise;
      // RULE3 drivers off
      dqOe <= rdBeat && clkRun;
      dqsOut <= (rdBeat && clkRun) ? {2{~rdPhase}} : 2'h0;
    end
  end

endmodule // dpf_ctrl_front

/* File: dpf_pkg.sv */
// Shared constants and types for the DDR2 control pin front end
package dpf_pkg;

  // Pin widths
  localparam int ADDR_W = 14;
  localparam int BANK_W = 2;
  localparam int NBANKS = 4;
  localparam int DQ_W = 16;
  localparam int MR_COUNT = 4;

  // Address field positions
  localparam int AP_BIT = 10;
  localparam int COL_W = 10;
  localparam int ROW_W = 13;

  // Extended mode register 1 termination enable bits (A2, A6)
  localparam int ODT_RTT0_BIT = 2;
  localparam int ODT_RTT1_BIT = 6;

  // Mode register index of the extended register 1
  localparam logic [1:0] EMR1_SEL = 2'h1;

  // Reset values
  localparam logic [ADDR_W-1:0] MR_RESET = 14'h0000;
  localparam logic [ROW_W-1:0] ROW_RESET = 13'h0000;

  // Decoded command codes: {csN, rasN, casN, weN}
  typedef enum logic [3:0] {
    CMD_MRS = 4'b0000,
    CMD_REF = 4'b0001,
    CMD_PRE = 4'b0010,
    CMD_ACT = 4'b0011,
    CMD_WR = 4'b0100,
    CMD_RD = 4'b0101,
    CMD_NOP = 4'b0111
  } dpf_cmd_type;

  // Power state of the device
  typedef enum logic [1:0] {
    PWR_ON = 2'b00,
    PWR_PRE_PD = 2'b01,
    PWR_ACT_PD = 2'b10,
    PWR_SELF_REF = 2'b11
  } dpf_pwr_type;

  // Command pins sampled at one clock crossing
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } dpf_cmdpins_type;

  // Decoded access handed to the array side
  typedef struct packed {
    logic rd;
    logic wr;
    logic autoPre;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
  } dpf_access_type;

endpackage

/* File: dpf_mode_regs.sv */
// Small memory holding the mode register op-codes
`timescale 1ns/1ps
module dpf_mode_regs #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrSel,
  input wire logic [WIDTH-1:0] wrData,
  // Registered read port
  input wire logic [$clog2(DEPTH)-1:0] rdSel,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage, cleared at reset so the device starts with defaults
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (wrEn) begin
      mem[wrSel] <= wrData;
    end
  end

  // Read data comes out of a register; same-cycle write is bypassed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else if (wrEn && wrSel == rdSel) begin
      rdData <= wrData;
    end else begin
      rdData <= mem[rdSel];
    end
  end

endmodule // dpf_mode_regs

/* File: dpf_ctrl_front_assertions.sv */
// Concurrent checks on the DDR2 control pin front end ports
`timescale 1ns/1ps
module dpf_ctrl_front_assertions #(
  parameter int ADDR_W = 14,
  parameter int NBANKS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command pins
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [dpf_pkg::BANK_W-1:0] bankAddr,
  input wire logic [ADDR_W-1:0] addr,
  // Decoded outputs
  input wire dpf_pkg::dpf_access_type access,
  input wire logic [dpf_pkg::ROW_W-1:0] actRow,
  input wire logic [dpf_pkg::BANK_W-1:0] actBank,
  input wire logic actStrobe,
  input wire logic refStrobe,
  input wire logic [NBANKS-1:0] bankOpen,
  // Power state
  input wire dpf_pkg::dpf_pwr_type pwrState,
  input wire logic clkRun,
  input wire logic cmdBufOn,
  input wire logic clkBufOn
);
  // One domain, so clock and reset are set once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Pin patterns; answers land three edges after the pins
  sequence s_pre_all;
    !csN && !rasN && casN && !weN && addr[dpf_pkg::AP_BIT] && cmdBufOn;
  endsequence
  sequence s_idle_drop;
    pwrState == dpf_pkg::PWR_ON && bankOpen == '0 && $fell(cke) && csN;
  endsequence
  sequence s_open_drop;
    pwrState == dpf_pkg::PWR_ON && bankOpen != '0 && $fell(cke) && csN;
  endsequence
  sequence s_low_hold;
    (!cke && csN) [*4];
  endsequence

  property p_mask;
    csN |-> ##3 !(actStrobe || refStrobe || access.rd || access.wr);
  endproperty
  a_mask: assert property (p_mask)
    else $error("deselected command acted");
  property p_act;
    actStrobe |-> actBank == $past(bankAddr, 3) && bankOpen[actBank]
      && actRow == 13'($past(addr, 3));
  endproperty
  a_act: assert property (p_act)
    else $error("activate fields wrong");
  property p_rdwr;
    (access.rd || access.wr) |-> access.bank == $past(bankAddr, 3)
      && access.col == 10'($past(addr, 3))
      && access.autoPre == 1'($past(addr, 3) >> 10);
  endproperty
  a_rdwr: assert property (p_rdwr)
    else $error("access fields wrong");
  property p_pre_all;
    s_pre_all |-> ##3 bankOpen == '0;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("banks left open");
  property p_pd;
    (pwrState == dpf_pkg::PWR_PRE_PD || pwrState == dpf_pkg::PWR_ACT_PD)
      [*2] |-> clkBufOn && !cmdBufOn && !clkRun;
  endproperty
  a_pd: assert property (p_pd)
    else $error("power-down buffers wrong");
  property p_sr;
    (pwrState == dpf_pkg::PWR_SELF_REF) [*2]
      |-> !clkBufOn && !cmdBufOn && !clkRun;
  endproperty
  a_sr: assert property (p_sr)
    else $error("self refresh buffers wrong");
  property p_pd_pre;
    s_idle_drop ##1 s_low_hold |-> pwrState == dpf_pkg::PWR_PRE_PD;
  endproperty
  a_pd_pre: assert property (p_pd_pre)
    else $error("no precharge power-down");
  property p_pd_act;
    s_open_drop ##1 s_low_hold |-> pwrState == dpf_pkg::PWR_ACT_PD;
  endproperty
  a_pd_act: assert property (p_pd_act)
    else $error("no active power-down");
endmodule // dpf_ctrl_front_assertions

bind dpf_ctrl_front dpf_ctrl_front_assertions #(
  .ADDR_W(ADDR_W),
  .NBANKS(NBANKS)
) i_chk (
  .clk, .rst_n, .cke, .csN, .rasN, .casN, .weN, .bankAddr, .addr,
  .access, .actRow, .actBank, .actStrobe, .refStrobe, .bankOpen,
  .pwrState, .clkRun, .cmdBufOn, .clkBufOn
);

/* File: dpf_ctrl_model.sv */
// Behavioural DDR2 controller driving the command pins
`timescale 1ns/1ps
module dpf_ctrl_model (
  // Clock
  input wire logic clk,
  // Command pins
  output logic cke,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [dpf_pkg::BANK_W-1:0] bankAddr,
  output logic [dpf_pkg::ADDR_W-1:0] addr,
  output logic odt
);
  // Deselected, CKE low until the bench powers up
  initial begin
    cke = 1'b0;
    {csN, rasN, casN, weN} = 4'hf;
    bankAddr = 2'h0;
    addr = 14'h0000;
    odt = 1'b0;
  end
  task automatic issue(input logic [3:0] code,
      input logic [1:0] b, input logic [13:0] a, input logic c);
    @(posedge clk);
    {csN, rasN, casN, weN} <= code;
    bankAddr <= b;
    addr <= a;
    cke <= c;
    @(posedge clk);
    // Stale bus shows inverted so it never passes for valid
    {csN, rasN, casN, weN} <= 4'hf;
    bankAddr <= ~b;
    addr <= ~a;
  endtask
  task automatic pins(input logic c, input logic o);
    @(posedge clk);
    cke <= c;
    odt <= o;
  endtask
endmodule // dpf_ctrl_model

/* File: dpf_ctrl_front_tb.sv */
// Self-checking bench for the DDR2 control pin front end
`timescale 1ns/1ps
`define CHK(g, e) begin \
  totalChecks++; \
  if ((g) !== (e)) begin \
    nErrors++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); \
  end \
end
module dpf_ctrl_front_tb;
  logic clk, rst_n, cke, csN, rasN, casN, weN, odt;
  logic [1:0] bankAddr, actBank, arrByteEn, dqsOut;
  logic [13:0] addr, modeOut;
  logic [15:0] wrDq = 16'h0000;
  logic [15:0] rdRise = 16'h0000;
  logic [15:0] rdFall = 16'h0000;
  logic [15:0] arrData, dqOut;
  logic [1:0] wrMask = 2'b00;
  logic wrBeat = 1'b0;
  logic rdBeat = 1'b0;
  logic [12:0] actRow;
  logic [3:0] bankOpen;
  logic actStrobe, refStrobe, dqOe, clkRun, cmdBufOn, clkBufOn, termOn;
  dpf_pkg::dpf_access_type access;
  dpf_pkg::dpf_pwr_type pwrState;
  int nErrors = 0;
  int totalChecks = 0;
  // Controller model and device
  dpf_ctrl_model i_ctl (
    .clk, .cke, .csN, .rasN, .casN, .weN, .bankAddr, .addr, .odt
  );
  dpf_ctrl_front i_dut (
    .clk, .rst_n, .cke, .csN, .rasN, .casN, .weN, .bankAddr, .addr, .odt,
    .wrDq, .wrMask, .wrBeat, .rdRise, .rdFall, .rdBeat, .access, .actRow,
    .actBank, .actStrobe, .refStrobe, .bankOpen, .modeOut, .arrData,
    .arrByteEn, .dqOut, .dqOe, .dqsOut, .pwrState, .clkRun, .cmdBufOn,
    .clkBufOn, .termOn
  );
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Step past edges so registered outputs have landed
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Command with CKE high, returns at its answer cycle
  task automatic cmd(input logic [3:0] c, input logic [1:0] b,
      input logic [13:0] a);
    i_ctl.issue(c, b, a, 1'b1);
    waitc(2);
  endtask
  task automatic wrapUp();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Activate, deselect, write, read with auto-precharge
  task automatic tCmds();
    cmd(dpf_pkg::CMD_ACT, 2'h2, 14'h2abc);
    `CHK(actStrobe, 1'b1)
    `CHK(actRow, 13'h0abc)
    `CHK({actBank, bankOpen}, 6'h24)
    cmd(4'hb, 2'h1, 14'h0001);
    `CHK(actStrobe, 1'b0)
    `CHK(bankOpen, 4'h4)
    cmd(dpf_pkg::CMD_WR, 2'h2, 14'h0123);
    `CHK(access, {3'b010, 2'h2, 10'h123})
    cmd(dpf_pkg::CMD_RD, 2'h2, 14'h0455);
    `CHK(access, {3'b101, 2'h2, 10'h055})
    waitc(1);
    `CHK(bankOpen, 4'h0)
    cmd(dpf_pkg::CMD_REF, 2'h0, 14'h0000);
    `CHK({refStrobe, pwrState}, 3'h4)
    $display("commands done");
  endtask
  // Single and all-bank precharge
  task automatic tPre();
    cmd(dpf_pkg::CMD_ACT, 2'h0, 14'h0011);
    cmd(dpf_pkg::CMD_ACT, 2'h1, 14'h0022);
    cmd(dpf_pkg::CMD_PRE, 2'h0, 14'h0000);
    `CHK(bankOpen, 4'h2)
    cmd(dpf_pkg::CMD_ACT, 2'h3, 14'h0033);
    `CHK(bankOpen, 4'ha)
    cmd(dpf_pkg::CMD_PRE, 2'h0, 14'h0400);
    `CHK(bankOpen, 4'h0)
    $display("precharge done");
  endtask
  // Mode registers and termination gating
  task automatic tMode();
    cmd(dpf_pkg::CMD_MRS, 2'h1, 14'h0044);
    waitc(1);
    `CHK(modeOut, 14'h0044)
    cmd(dpf_pkg::CMD_MRS, 2'h0, 14'h0252);
    waitc(1);
    `CHK(modeOut, 14'h0252)
    cmd(dpf_pkg::CMD_NOP, 2'h1, 14'h0000);
    waitc(1);
    `CHK(modeOut, 14'h0044)
    i_ctl.pins(1'b1, 1'b1);
    waitc(5);
    `CHK(termOn, 1'b1)
    cmd(dpf_pkg::CMD_MRS, 2'h1, 14'h0000);
    waitc(2);
    `CHK(termOn, 1'b0)
    i_ctl.pins(1'b1, 1'b0);
    $display("mode done");
  endtask
  // Masked write beat alongside a two-beat read, rise then fall
  task automatic tData();
    @(posedge clk);
    wrDq <= 16'h5aa5;
    wrMask <= 2'b01;
    wrBeat <= 1'b1;
    rdRise <= 16'h1234;
    rdFall <= 16'hedcb;
    rdBeat <= 1'b1;
    @(posedge clk);
    wrBeat <= 1'b0;
    wrDq <= 16'ha55a;
    #1;
    for (int k = 0; k < 6 && dqOe !== 1'b1; k++) waitc(1);
    `CHK({dqOe, dqsOut, dqOut}, 19'h71234)
    @(posedge clk);
    rdBeat <= 1'b0;
    #1;
    `CHK({dqOe, dqsOut, dqOut}, 19'h4edcb)
    for (int k = 0; k < 6 && arrByteEn === 2'b00; k++) waitc(1);
    `CHK({arrByteEn, arrData[15:8]}, 10'h25a)
    `CHK(dqOe, 1'b0)
    $display("data done");
  endtask
  // Power-down, active power-down, self refresh
  task automatic tPower();
    i_ctl.pins(1'b0, 1'b0);
    waitc(6);
    `CHK(pwrState, dpf_pkg::PWR_PRE_PD)
    `CHK({clkBufOn, cmdBufOn, clkRun}, 3'b100)
    i_ctl.pins(1'b1, 1'b0);
    waitc(6);
    `CHK(pwrState, dpf_pkg::PWR_ON)
    cmd(dpf_pkg::CMD_ACT, 2'h1, 14'h0001);
    i_ctl.pins(1'b0, 1'b0);
    waitc(6);
    `CHK(pwrState, dpf_pkg::PWR_ACT_PD)
    i_ctl.pins(1'b1, 1'b0);
    waitc(6);
    cmd(dpf_pkg::CMD_PRE, 2'h0, 14'h0400);
    i_ctl.issue(dpf_pkg::CMD_REF, 2'h0, 14'h0000, 1'b0);
    waitc(6);
    `CHK(pwrState, dpf_pkg::PWR_SELF_REF)
    `CHK({clkBufOn, cmdBufOn, clkRun}, 3'b000)
    i_ctl.pins(1'b1, 1'b0);
    waitc(6);
    `CHK(pwrState, dpf_pkg::PWR_ON)
    $display("power done");
  endtask
  // Reset, power up, then the scenarios
  initial begin
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    i_ctl.pins(1'b1, 1'b0);
    waitc(6);
    `CHK({pwrState, clkRun, cmdBufOn}, 4'h3)
    tCmds();
    tPre();
    tMode();
    tData();
    tPower();
    wrapUp();
  end
  // Watchdog so a hang still reaches the report
  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    wrapUp();
  end
endmodule // dpf_ctrl_front_tb
